// file: block_interrupt_status_summary.sv
// Purpose: per-channel interrupt summary with APB register access
// Assumes: pending and source status inputs are on clk_i
// Notes:   answers every access with one wait state
//
// Overview of operation
// - summary register at index 0x21, bit n for channel n.
// - summary bit is 1 while the channel has a pending interrupt and its gate bit is 1.
// - summary bits are read-only; writes leave them unchanged.
// - a set summary bit holds until the source status is read.
// - gate bit at index 0x20 blocks a channel when zero.
`timescale 1ns/10ps
`include "chan_irq_regs.svh"

module block_interrupt_status_summary (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   reset_i,
	// apb slave
	input  wire logic [11:0]            paddr_i,
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire chan_irq_pkg::word_t    pwdata_i,
	output logic                        pready_o,
	output chan_irq_pkg::word_t         prdata_o,
	output logic                        pslverr_o,
	// channel sources
	input  wire chan_irq_pkg::chan_vec_t src_pending_i,
	input  wire logic [23:0]            src_status_i,
	output chan_irq_pkg::chan_vec_t     src_status_rd_o,
	output chan_irq_pkg::chan_vec_t     gate_o,
	// interrupt
	output logic                        irq_o
);
	import chan_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	logic      pready_q;
	logic      pready_d;
	word_t     prdata_q;
	word_t     prdata_d;
	logic      pslverr_q;
	logic      pslverr_d;
	chan_vec_t gate_q;
	chan_vec_t gate_d;
	chan_vec_t summary_q;
	chan_vec_t summary_d;
	chan_vec_t evt_q;
	chan_vec_t evt_d;
	chan_vec_t mask_q;
	chan_vec_t mask_d;
	chan_vec_t src_rd_q;
	chan_vec_t src_rd_d;
	logic      irq_q;
	logic      irq_d;

	////////////////////////////////////////////////////////////////////////
	// decode
	reg_idx_t  idx;
	logic      aligned;
	logic      access;
	logic      done;
	logic      do_wr;
	logic      do_rd;
	logic      hit_gate;
	logic      hit_summary;
	logic      hit_evt;
	logic      hit_mask;
	chan_vec_t hit_src;
	logic      mapped;
	chan_vec_t src_rd;
	chan_vec_t raise;
	chan_vec_t live;

	always_comb begin
		idx         = paddr_i[9:2];
		aligned     = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0);
		// answer phase: one wait state, then pready
		access      = psel_i & penable_i & ~pready_q;
		done        = psel_i & penable_i & pready_q;
		do_wr       = done & pwrite_i & ~pslverr_q;
		do_rd       = done & ~pwrite_i & ~pslverr_q;
		hit_gate    = aligned && (idx == `GATE_IDX);
		hit_summary = aligned && (idx == `SUMMARY_IDX);
		hit_evt     = aligned && (idx == `EVT_STATUS_IDX);
		hit_mask    = aligned && (idx == `EVT_MASK_IDX);
		hit_src[0]  = aligned && (idx == `SRC_STATUS0_IDX);
		hit_src[1]  = aligned && (idx == `SRC_STATUS1_IDX);
		hit_src[2]  = aligned && (idx == `SRC_STATUS2_IDX);
		mapped      = hit_gate | hit_summary | hit_evt | hit_mask | (|hit_src);
		// a source status read is what releases a held summary bit
		src_rd      = do_rd ? hit_src : 3'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// apb answer
	always_comb begin
		pready_d  = access;
		pslverr_d = pslverr_q;
		prdata_d  = prdata_q;
		if (access) begin
			pslverr_d = ~mapped;
			prdata_d  = 32'h0;
			if (!pwrite_i) begin
				// bits 31 to 3 of the summary stay zero
				if (hit_summary) prdata_d = {29'h0, summary_q};
				if (hit_gate)    prdata_d = {29'h0, gate_q};
				if (hit_evt)     prdata_d = {29'h0, evt_q};
				if (hit_mask)    prdata_d = {29'h0, mask_q};
				if (hit_src[0])  prdata_d = {24'h0, src_status_i[7:0]};
				if (hit_src[1])  prdata_d = {24'h0, src_status_i[15:8]};
				if (hit_src[2])  prdata_d = {24'h0, src_status_i[23:16]};
			end
		end else if (!psel_i) begin
			pslverr_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gate and mask registers
	always_comb begin
		gate_d = gate_q;
		mask_d = mask_q;
		if (do_wr && hit_gate) gate_d = pwdata_i[2:0];
		if (do_wr && hit_mask) mask_d = pwdata_i[2:0];
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gate_q <= `GATE_RST;
			mask_q <= `EVT_MASK_RST;
		end else begin
			gate_q <= gate_d;
			mask_q <= mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel summary
	// no write path reaches summary_q at all
	always_comb begin
		live      = src_pending_i & gate_q;
		// pending sets, a source read releases; pending wins the tie
		summary_d = live | (summary_q & ~src_rd);
		src_rd_d  = src_rd;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			summary_q <= `SUMMARY_RST;
			src_rd_q  <= 3'h0;
		end else begin
			summary_q <= summary_d;
			src_rd_q  <= src_rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event status and interrupt
	always_comb begin
		raise = summary_d & ~summary_q;
		evt_d = evt_q;
		if (do_wr && hit_evt) evt_d = evt_q & ~pwdata_i[2:0];
		// a new event in the clear cycle survives
		evt_d = evt_d | raise;
		irq_d = |(evt_d & mask_d);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			evt_q <= `EVT_STATUS_RST;
			irq_q <= 1'b0;
		end else begin
			evt_q <= evt_d;
			irq_q <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign pready_o        = pready_q;
	assign prdata_o        = prdata_q;
	assign pslverr_o       = pslverr_q;
	assign src_status_rd_o = src_rd_q;
	assign gate_o          = gate_q;
	assign irq_o           = irq_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	summary_read_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(pready_q && !pwrite_i && psel_i && hit_summary && !pslverr_q)
			|-> (prdata_o == {29'h0, $past(summary_q)}))
		else $error("summary read data mismatch");

	summary_set_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|live) |=> ((summary_q & $past(live)) == $past(live)))
		else $error("pending channel not flagged");

	summary_drop_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|(src_rd & ~live)) |=> ((summary_q & $past(src_rd & ~live)) == 3'h0))
		else $error("idle channel still flagged after read");

	summary_ro_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(do_wr && hit_summary)
			|=> ((summary_q & $past(summary_q)) == $past(summary_q)))
		else $error("summary changed by write");

	summary_hold_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|summary_q) |=> (($past(summary_q) & ~summary_q & ~$past(src_rd)) == 3'h0))
		else $error("summary dropped without source read");

	gate_block_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|(~gate_q & ~summary_q))
			|=> ((summary_q & $past(~gate_q & ~summary_q)) == 3'h0))
		else $error("gated channel raised summary");

	summary_reset_a : assert property (
		@(posedge clk_i)
		(!reset_i && $past(reset_i)) |-> (summary_q == 3'h0))
		else $error("summary not zero after reset");

	upper_zero_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(pready_q && psel_i && hit_summary) |-> (prdata_o[31:3] == 29'h0))
		else $error("summary upper bits not zero");

	irq_level_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|(evt_q & mask_q)) |-> irq_o)
		else $error("interrupt missing for unmasked event");

	src_strobe_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(do_rd && hit_src[1]) |=> src_status_rd_o[1] ##1 !src_status_rd_o[1])
		else $error("source read strobe wrong");

	pready_wait_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(psel_i && penable_i && !pready_q) |=> pready_o)
		else $error("ready not given after one wait state");

	pready_pulse_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		pready_o |=> !pready_o)
		else $error("ready held longer than one cycle");

	slave_error_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(pready_o && psel_i) |-> (pslverr_o == !mapped))
		else $error("error flag does not match decode");

	gate_write_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(do_wr && hit_gate) |=> (gate_o == $past(pwdata_i[2:0])))
		else $error("gate write not applied");

	summary_rise_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|(summary_q & ~$past(summary_q)))
			|-> ((summary_q & ~$past(summary_q) & ~$past(live)) == 3'h0))
		else $error("summary rose without gated pending");

	src_data_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(pready_o && psel_i && !pwrite_i && hit_src[0] && !pslverr_o)
			|-> (prdata_o == {24'h0, $past(src_status_i[7:0])}))
		else $error("source status read data mismatch");

	strobe_cause_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|src_status_rd_o) |-> $past(done && !pwrite_i && !pslverr_q))
		else $error("source read strobe without a read");

	evt_set_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(|raise) |=> ((evt_q & $past(raise)) == $past(raise)))
		else $error("summary rise did not set event status");

	evt_clear_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		(do_wr && hit_evt) |=> ((evt_q & $past(pwdata_i[2:0] & ~raise)) == 3'h0))
		else $error("event status not cleared by write");

	irq_idle_a : assert property (
		@(posedge clk_i) disable iff (reset_i)
		!(|(evt_q & mask_q)) |-> !irq_o)
		else $error("interrupt without unmasked event");

endmodule : block_interrupt_status_summary

// file: chan_irq_pkg.sv
// Purpose: shared types for the interrupt summary block
// Assumes: three channels, 8-bit source status registers
// Notes:   constants live in chan_irq_regs.svh
package chan_irq_pkg;
	typedef logic [2:0]  chan_vec_t;
	typedef logic [7:0]  reg_idx_t;
	typedef logic [31:0] word_t;
endpackage : chan_irq_pkg

// file: chan_irq_regs.svh
// Purpose: register indices, reset values and sizes for the interrupt summary block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef CHAN_IRQ_REGS_SVH
`define CHAN_IRQ_REGS_SVH

// register indices
`define SRC_STATUS0_IDX  8'h02
`define SRC_STATUS1_IDX  8'h0a
`define SRC_STATUS2_IDX  8'h12
`define GATE_IDX         8'h20
`define SUMMARY_IDX      8'h21
`define EVT_STATUS_IDX   8'h22
`define EVT_MASK_IDX     8'h23

// reset values
`define GATE_RST         3'h0
`define SUMMARY_RST      3'h0
`define EVT_STATUS_RST   3'h0
`define EVT_MASK_RST     3'h0

// field layout
`define CHAN_BITS        3
`define SRC_BYTE_BITS    8

`endif

// file: testbench.sv
// Purpose: self-checking bench for the channel interrupt summary block
// Assumes: one wait state apb slave, registered outputs
// Notes:   random channel events with fixed seed, corner cases among them
`timescale 1ns/10ps
`include "chan_irq_regs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end

module testbench;
	import chan_irq_pkg::*;
	logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, err;
	logic [11:0] paddr_i;
	logic [23:0] src_status_i;
	word_t       pwdata_i, prdata_o, rd;
	chan_vec_t   src_pending_i, src_status_rd_o, gate_o, m;
	int          err_total, compares, cycles, ch, strobes[3], exp_strb[3];
	reg_idx_t    rst_idx[4] = '{`GATE_IDX, `SUMMARY_IDX, `EVT_STATUS_IDX, `EVT_MASK_IDX};

	block_interrupt_status_summary i_block_interrupt_status_summary (
		.clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.src_pending_i(src_pending_i), .src_status_i(src_status_i),
		.src_status_rd_o(src_status_rd_o), .gate_o(gate_o), .irq_o(irq_o));

	////////////////////////////////////////////////////////////////////////////////
	function automatic word_t sum_word(chan_vec_t v);
		return {29'h0, v};
	endfunction : sum_word

	function automatic reg_idx_t src_idx(int c);
		return (c == 0) ? `SRC_STATUS0_IDX : (c == 1) ? `SRC_STATUS1_IDX : `SRC_STATUS2_IDX;
	endfunction : src_idx

	task automatic stop_test();
		if (err_total == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	// request held until pready seen high; no fixed latency assumed
	task automatic apb(input logic w, input reg_idx_t idx, input word_t wd);
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		paddr_i   <= {2'h0, idx, 2'h0};
		pwrite_i  <= w;
		pwdata_i  <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 5000) begin
			err_total++;
			stop_test();
		end
	end

	// strobe pulses last one cycle, so mid-cycle counting sees each once
	always @(negedge clk_i) begin
		for (int i = 0; i < 3; i++) if (src_status_rd_o[i] === 1'b1) strobes[i]++;
	end

	initial begin
		reset_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
		paddr_i = 12'h000; pwdata_i = 32'h0; src_pending_i = 3'h0; src_status_i = 24'h0;
		void'($urandom(90854));
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, rst_idx[i], 32'h0);
			`CHK("reset value", 32'h0, rd)
		end
		src_pending_i <= 3'h7;
		repeat (4) @(posedge clk_i);
		apb(1'b0, `SUMMARY_IDX, 32'h0);
		`CHK("gated summary", 32'h0, rd)
		src_pending_i <= 3'h0;
		apb(1'b1, `GATE_IDX, 32'hffff_ffff);
		#1 `CHK("gate_o", 3'h7, gate_o)
		apb(1'b1, `EVT_MASK_IDX, 32'h7);
		for (int k = 0; k < 12; k++) begin
			ch = (k < 3) ? k : $urandom_range(2, 0);
			m = 3'h1 << ch;
			src_status_i <= 24'($urandom);
			src_pending_i <= m;
			repeat (3) @(posedge clk_i);
			src_pending_i <= 3'h0;
			repeat (2) @(posedge clk_i);
			apb(1'b0, `SUMMARY_IDX, 32'h0);
			`CHK("summary set", sum_word(m), rd)
			`CHK("irq_o", 1'b1, irq_o)
			// inverted data would both clear the set bit and set the others
			apb(1'b1, `SUMMARY_IDX, ~sum_word(m));
			`CHK("summary write err", 1'b0, err)
			apb(1'b0, `SUMMARY_IDX, 32'h0);
			`CHK("summary held", sum_word(m), rd)
			apb(1'b0, src_idx(ch), 32'h0);
			`CHK("source status", {24'h0, src_status_i[ch*8 +: 8]}, rd)
			exp_strb[ch]++;
			apb(1'b0, `SUMMARY_IDX, 32'h0);
			`CHK("summary cleared", 32'h0, rd)
			apb(1'b0, `EVT_STATUS_IDX, 32'h0);
			`CHK("event status", sum_word(m), rd)
			apb(1'b1, `EVT_STATUS_IDX, sum_word(m));
			repeat (2) @(posedge clk_i);
			`CHK("irq cleared", 1'b0, irq_o)
		end
		// pending still high at the source read: set wins, bit stays
		src_pending_i <= 3'h2;
		repeat (3) @(posedge clk_i);
		apb(1'b0, `SRC_STATUS1_IDX, 32'h0);
		exp_strb[1]++;
		apb(1'b0, `SUMMARY_IDX, 32'h0);
		`CHK("summary pending", 32'h2, rd)
		src_pending_i <= 3'h0;
		// a write to a source index is ignored: no error, no strobe
		apb(1'b1, src_idx(0), 32'hffff_ffff);
		`CHK("source write err", 1'b0, err)
		apb(1'b0, 8'h30, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		for (int i = 0; i < 3; i++) `CHK("read strobes", exp_strb[i], strobes[i])
		stop_test();
	end
endmodule : testbench
